// [design/fieldbus_status_led_driver.sv]
`timescale 1ns/1ns
// Functional notes
// - port LED steady green on valid idle link, dark when link invalid
// - port LED flickers green while link valid and frames pass
// - bus-state LED steady in full exchange state
// - bus-state LED blinks 200 ms on, 200 ms off in mailbox-only state
// - bus-state LED single flash 200 ms, 1000 ms dark in inputs-only
// - bus-state LED flickers 50/50 ms booting, firmware update, download
// - bus-state LED dark in initial state
// - error LED steady red after interface watchdog expiry
// - error LED blinks 200/200 ms on configuration error
// - error LED flickers 50/50 ms on boot error: init with change 0x01
// - error LED single flash on autonomous state change with change 0x01
// - error LED double flash on application watchdog expiry
// - station alias accepted from network or setup software
module fieldbus_status_led_driver #(
    parameter logic [led_pkg::CNT_W-1:0] fast_cyc  = led_pkg::FLICKER_CYC,
    parameter logic [led_pkg::CNT_W-1:0] slow_cyc  = led_pkg::BLINK_CYC,
    parameter logic [led_pkg::CNT_W-1:0] pause_cyc = led_pkg::PAUSE_CYC
) (
    // clock and reset
    input  wire logic                              clock_in,
    input  wire logic                              rst_in,
    // link status
    input  wire led_pkg::link_type                 link_in,
    // slave state and faults
    input  wire led_pkg::bus_state_type            bus_state_in,
    input  wire logic                              download_active_in,
    input  wire led_pkg::fault_type                fault_in,
    input  wire logic                              error_ack_in,
    // station alias sources
    input  wire led_pkg::alias_type                alias_net_in,
    input  wire led_pkg::alias_type                alias_tool_in,
    // indicators and status
    output logic [led_pkg::PORT_COUNT-1:0]         port_link_activity_led_out,
    output logic                                   bus_state_led_out,
    output logic                                   error_led_out,
    output logic [led_pkg::ALIAS_W-1:0]            station_alias_out,
    output logic                                   hif_watchdog_out,
    output logic                                   app_watchdog_out
);
    import led_pkg::*;

    logic [CNT_W-1:0]      flicker_cnt_q;
    logic                  flicker_q;
    logic [PORT_COUNT-1:0] port_led_q;
    pattern_type           bus_pat_q;
    pattern_type           bus_pat_d;
    pattern_type           err_pat_q;
    pattern_type           err_pat_d;
    logic                  hif_wd_q;
    logic                  app_wd_q;
    logic                  boot_error;
    logic                  auto_change;
    logic [ALIAS_W-1:0]    alias_q;

    // ****************************************
    // shared link flicker clock
    // ****************************************
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flicker_cnt_q <= CNT_ZERO;
            flicker_q     <= 1'b1;
        end else if (flicker_cnt_q >= fast_cyc - CNT_ONE) begin
            flicker_cnt_q <= CNT_ZERO;
            flicker_q     <= ~flicker_q;
        end else begin
            flicker_cnt_q <= flicker_cnt_q + CNT_ONE;
        end
    end

    // ****************************************
    // port link/activity LEDs
    // ****************************************
    for (genvar i = 0; i < PORT_COUNT; i++) begin : g_port
        logic [CNT_W-1:0] hold_q;

        always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
                hold_q <= CNT_ZERO;
            end else if (link_in.activity[i]) begin
                hold_q <= slow_cyc;
            end else if (hold_q != CNT_ZERO) begin
                hold_q <= hold_q - CNT_ONE;
            end
        end

        always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
                port_led_q[i] <= 1'b0;
            end else if (!link_in.link_valid[i]) begin
                port_led_q[i] <= 1'b0;
            end else if (link_in.activity[i] || hold_q != CNT_ZERO) begin
                port_led_q[i] <= flicker_q;
            end else begin
                port_led_q[i] <= 1'b1;
            end
        end

        chk_link_dark: assert property (
            @(posedge clock_in) disable iff (rst_in)
            !link_in.link_valid[i] |=> !port_led_q[i])
            else $error("port LED lit without valid link");

        chk_link_steady: assert property (
            @(posedge clock_in) disable iff (rst_in)
            link_in.link_valid[i] && !link_in.activity[i]
                && hold_q == CNT_ZERO |=> port_led_q[i])
            else $error("idle valid link LED not steady");

        chk_link_flicker: assert property (
            @(posedge clock_in) disable iff (rst_in)
            link_in.link_valid[i] && link_in.activity[i]
                |=> port_led_q[i] == $past(flicker_q))
            else $error("active link LED not following flicker");
    end

    assign port_link_activity_led_out = port_led_q;

    // ****************************************
    // bus-state pattern select
    // ****************************************
    always_comb begin
        case (bus_state_in)
            full_exchange_state:   bus_pat_d = pat_on;
            mailbox_only_state:    bus_pat_d = pat_blink;
            inputs_only_state:     bus_pat_d = pat_single;
            st_booting:            bus_pat_d = pat_flicker;
            firmware_update_state: bus_pat_d = pat_flicker;
            default:               bus_pat_d = pat_off;
        endcase
        if (download_active_in) begin
            bus_pat_d = pat_flicker;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            bus_pat_q <= pat_off;
        end else begin
            bus_pat_q <= bus_pat_d;
        end
    end

    led_pattern_gen #(
        .fast_cyc  (fast_cyc),
        .slow_cyc  (slow_cyc),
        .pause_cyc (pause_cyc)
    ) u_bus_led (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .pattern_in (bus_pat_q),
        .led_out    (bus_state_led_out)
    );

    // ****************************************
    // watchdog fault latches
    // ****************************************
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            hif_wd_q <= 1'b0;
        end else if (fault_in.hif_watchdog) begin
            hif_wd_q <= 1'b1;
        end else if (error_ack_in) begin
            hif_wd_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            app_wd_q <= 1'b0;
        end else if (fault_in.app_watchdog) begin
            app_wd_q <= 1'b1;
        end else if (error_ack_in) begin
            app_wd_q <= 1'b0;
        end
    end

    assign hif_watchdog_out = hif_wd_q;
    assign app_watchdog_out = app_wd_q;

    // ****************************************
    // error pattern select
    // ****************************************
    assign boot_error  = (bus_state_in == st_init)
                       && (fault_in.al_change == CHANGE_ERROR_CODE);
    assign auto_change = fault_in.autonomous_change
                       && (fault_in.al_change == CHANGE_ERROR_CODE);

    always_comb begin
        if (hif_wd_q) begin
            err_pat_d = pat_on;
        end else if (app_wd_q) begin
            err_pat_d = pat_double;
        end else if (boot_error) begin
            err_pat_d = pat_flicker;
        end else if (auto_change) begin
            err_pat_d = pat_single;
        end else if (fault_in.config_error) begin
            err_pat_d = pat_blink;
        end else begin
            err_pat_d = pat_off;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            err_pat_q <= pat_off;
        end else begin
            err_pat_q <= err_pat_d;
        end
    end

    led_pattern_gen #(
        .fast_cyc  (fast_cyc),
        .slow_cyc  (slow_cyc),
        .pause_cyc (pause_cyc)
    ) u_err_led (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .pattern_in (err_pat_q),
        .led_out    (error_led_out)
    );

    // ****************************************
    // station alias
    // ****************************************
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            alias_q <= ALIAS_RESET;
        end else if (alias_net_in.valid) begin
            alias_q <= alias_net_in.value;
        end else if (alias_tool_in.valid) begin
            alias_q <= alias_tool_in.value;
        end
    end

    assign station_alias_out = alias_q;

    // ****************************************
    // checks
    // ****************************************
    chk_bus_full_on: assert property (
        @(posedge clock_in) disable iff (rst_in)
        bus_state_in == full_exchange_state && !download_active_in
            |-> ##2 bus_state_led_out)
        else $error("bus LED not lit in full exchange");

    chk_bus_init_dark: assert property (
        @(posedge clock_in) disable iff (rst_in)
        bus_state_in == st_init && !download_active_in
            ##1 bus_state_in == st_init && !download_active_in
            |-> ##1 !bus_state_led_out)
        else $error("bus LED lit in initial state");

    chk_bus_flicker_sel: assert property (
        @(posedge clock_in) disable iff (rst_in)
        download_active_in |=> bus_pat_q == pat_flicker)
        else $error("download did not select flicker");

    chk_wd_steady: assert property (
        @(posedge clock_in) disable iff (rst_in)
        hif_wd_q ##1 hif_wd_q |-> ##1 error_led_out)
        else $error("error LED not steady on watchdog");

    chk_wd_sticky: assert property (
        @(posedge clock_in) disable iff (rst_in)
        fault_in.hif_watchdog |=> hif_wd_q)
        else $error("watchdog set lost against clear");

    chk_err_order: assert property (
        @(posedge clock_in) disable iff (rst_in)
        app_wd_q && !hif_wd_q |=> err_pat_q == pat_double)
        else $error("app watchdog not chosen over lesser faults");

    chk_err_dark: assert property (
        @(posedge clock_in) disable iff (rst_in)
        err_pat_q == pat_off ##1 err_pat_q == pat_off |-> ##1 !error_led_out)
        else $error("error LED lit with no fault");

    chk_boot_error: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !hif_wd_q && !app_wd_q && bus_state_in == st_init
            && fault_in.al_change == CHANGE_ERROR_CODE
            |=> err_pat_q == pat_flicker)
        else $error("boot error not flickering");

    chk_alias_net: assert property (
        @(posedge clock_in) disable iff (rst_in)
        alias_net_in.valid |=> alias_q == $past(alias_net_in.value))
        else $error("network alias not taken");

    cov_full_exchange: cover property (
        @(posedge clock_in) disable iff (rst_in)
        bus_pat_q == pat_on ##2 bus_state_led_out);

    cov_double_flash: cover property (
        @(posedge clock_in) disable iff (rst_in)
        err_pat_q == pat_double ##1 error_led_out);

    cov_link_activity: cover property (
        @(posedge clock_in) disable iff (rst_in)
        link_in.link_valid[0] && link_in.activity[0]);

endmodule

// [design/led_pattern_gen.sv]
`timescale 1ns/1ns
module led_pattern_gen #(
    parameter logic [led_pkg::CNT_W-1:0] fast_cyc  = led_pkg::FLICKER_CYC,
    parameter logic [led_pkg::CNT_W-1:0] slow_cyc  = led_pkg::BLINK_CYC,
    parameter logic [led_pkg::CNT_W-1:0] pause_cyc = led_pkg::PAUSE_CYC
) (
    // clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 rst_in,
    // pattern select and drive
    input  wire led_pkg::pattern_type pattern_in,
    output logic                      led_out
);
    import led_pkg::*;

    pattern_type      pattern_q;
    logic [1:0]       phase_q;
    logic [1:0]       phase_d;
    logic [1:0]       last_phase;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] duration;
    logic             led_q;
    logic             led_d;

    // ****************************************
    // phase sequencing
    // ****************************************
    always_comb begin
        duration   = slow_cyc;
        last_phase = PHASE_LAST_PAIR;
        case (pattern_in)
            pat_flicker: begin
                duration = fast_cyc;
            end
            pat_single: begin
                if (phase_q[0]) begin
                    duration = pause_cyc;
                end
            end
            pat_double: begin
                last_phase = PHASE_LAST_QUAD;
                if (phase_q == PHASE_LAST_QUAD) begin
                    duration = pause_cyc;
                end
            end
            default: begin
            end
        endcase
        if (pattern_in != pattern_q) begin
            phase_d = PHASE_FIRST;
            count_d = CNT_ZERO;
        end else if (count_q >= duration - CNT_ONE) begin
            count_d = CNT_ZERO;
            phase_d = (phase_q == last_phase) ? PHASE_FIRST
                                              : phase_q + PHASE_STEP;
        end else begin
            count_d = count_q + CNT_ONE;
            phase_d = phase_q;
        end
        case (pattern_in)
            pat_off: led_d = 1'b0;
            pat_on:  led_d = 1'b1;
            default: led_d = ~phase_d[0];
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pattern_q <= pat_off;
            phase_q   <= PHASE_FIRST;
            count_q   <= CNT_ZERO;
        end else begin
            pattern_q <= pattern_in;
            phase_q   <= phase_d;
            count_q   <= count_d;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            led_q <= 1'b0;
        end else begin
            led_q <= led_d;
        end
    end

    assign led_out = led_q;

    // ****************************************
    // checks
    // ****************************************
    chk_restart_lit: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (pattern_in != pattern_q) |=> led_q == ($past(pattern_in) != pat_off))
        else $error("pattern change did not restart lit");

    chk_count_bound: assert property (
        @(posedge clock_in) disable iff (rst_in)
        count_q < pause_cyc)
        else $error("phase counter ran past longest phase");

endmodule

// [design/led_pkg.sv]
package led_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_HZ   = 100_000_000;
    localparam int MS_PER_S   = 1000;
    localparam int FLICKER_MS = 50;
    localparam int BLINK_MS   = 200;
    localparam int PAUSE_MS   = 1000;
    localparam int CNT_W      = 27;
    localparam logic [CNT_W-1:0] FLICKER_CYC =
        CNT_W'(FLICKER_MS * (CLOCK_HZ / MS_PER_S));
    localparam logic [CNT_W-1:0] BLINK_CYC =
        CNT_W'(BLINK_MS * (CLOCK_HZ / MS_PER_S));
    localparam logic [CNT_W-1:0] PAUSE_CYC =
        CNT_W'(PAUSE_MS * (CLOCK_HZ / MS_PER_S));
    localparam logic [CNT_W-1:0] CNT_ZERO = 27'h0000000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 27'h0000001;

    // ****************************************
    // pattern phases
    // ****************************************
    localparam logic [1:0] PHASE_FIRST     = 2'h0;
    localparam logic [1:0] PHASE_STEP      = 2'h1;
    localparam logic [1:0] PHASE_LAST_PAIR = 2'h1;
    localparam logic [1:0] PHASE_LAST_QUAD = 2'h3;

    // ****************************************
    // widths and codes
    // ****************************************
    localparam int PORT_COUNT = 2;
    localparam int CHANGE_W   = 8;
    localparam int ALIAS_W    = 16;
    localparam logic [CHANGE_W-1:0] CHANGE_ERROR_CODE = 8'h01;
    localparam logic [ALIAS_W-1:0]  ALIAS_RESET       = 16'h0000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        st_booting,
        st_init,
        mailbox_only_state,
        inputs_only_state,
        full_exchange_state,
        firmware_update_state
    } bus_state_type;

    typedef enum logic [2:0] {
        pat_off,
        pat_on,
        pat_blink,
        pat_flicker,
        pat_single,
        pat_double
    } pattern_type;

    typedef struct packed {
        logic                hif_watchdog;
        logic                app_watchdog;
        logic                config_error;
        logic                autonomous_change;
        logic [CHANGE_W-1:0] al_change;
    } fault_type;

    typedef struct packed {
        logic [PORT_COUNT-1:0] link_valid;
        logic [PORT_COUNT-1:0] activity;
    } link_type;

    typedef struct packed {
        logic               valid;
        logic [ALIAS_W-1:0] value;
    } alias_type;

endpackage

// [tb/fieldbus_status_led_driver_test.sv]
`timescale 1ns/1ns
module fieldbus_status_led_driver_test;
    import led_pkg::*;

    // ****************************************
    // bench setup
    // ****************************************
    localparam int FAST  = 4;
    localparam int SLOW  = 8;
    localparam int PAUSE = 20;

    typedef struct packed {
        int on;
        int offs;
    } pat_exp_type;

    typedef struct packed {
        bus_state_type st;
        logic          dl;
        logic [11:0]   flt;
        logic [3:0]    lnk;
        logic          p0;
        pat_exp_type   bus;
        pat_exp_type   err;
        pat_exp_type   p1;
    } row_type;

    logic                  clock_in           = 1'h0;
    logic                  rst_in             = 1'h1;
    link_type              link_in            = '0;
    bus_state_type         bus_state_in       = st_init;
    logic                  download_active_in = 1'h0;
    fault_type             fault_in           = '0;
    logic                  error_ack_in       = 1'h0;
    alias_type             alias_net_in       = '0;
    alias_type             alias_tool_in      = '0;
    logic [PORT_COUNT-1:0] port_led;
    logic                  bus_led;
    logic                  err_led;
    logic [ALIAS_W-1:0]    alias_out;
    logic                  hif_wd;
    logic                  app_wd;
    logic [2:0]            view_led;
    logic [31:0]           on_len [3];
    logic [31:0]           off_sum [3];
    logic [31:0]           cur_len [3];
    row_type               rows [9];
    int                    mismatches  = 0;
    int                    comparisons = 0;

    always #5 clock_in = ~clock_in;

    fieldbus_status_led_driver #(
        .fast_cyc  (CNT_W'(FAST)),
        .slow_cyc  (CNT_W'(SLOW)),
        .pause_cyc (CNT_W'(PAUSE))
    ) i_fieldbus_status_led_driver (
        .clock_in                   (clock_in),
        .rst_in                     (rst_in),
        .link_in                    (link_in),
        .bus_state_in               (bus_state_in),
        .download_active_in         (download_active_in),
        .fault_in                   (fault_in),
        .error_ack_in               (error_ack_in),
        .alias_net_in               (alias_net_in),
        .alias_tool_in              (alias_tool_in),
        .port_link_activity_led_out (port_led),
        .bus_state_led_out          (bus_led),
        .error_led_out              (err_led),
        .station_alias_out          (alias_out),
        .hif_watchdog_out           (hif_wd),
        .app_watchdog_out           (app_wd)
    );

    assign view_led = {port_led[1], err_led, bus_led};

    for (genvar g = 0; g < 3; g++) begin : gen_view
        led_viewer i_led_viewer (
            .clock_in    (clock_in),
            .rst_in      (rst_in),
            .led_in      (view_led[g]),
            .on_len_out  (on_len[g]),
            .off_sum_out (off_sum[g]),
            .cur_len_out (cur_len[g])
        );
    end

    // ****************************************
    // checking tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_pat(input int idx, input pat_exp_type e);
        if (e.on == 0) begin
            check(32'(view_led[idx]), 32'(e.offs));
            check(32'(cur_len[idx] > 32'h32), 32'h1);
        end else begin
            check(on_len[idx], 32'(e.on));
            check(off_sum[idx], 32'(e.offs));
        end
    endtask

    task automatic run_row(input row_type r);
        @(posedge clock_in);
        fault_in     <= '0;
        error_ack_in <= 1'h1;
        @(posedge clock_in);
        error_ack_in       <= 1'h0;
        bus_state_in       <= r.st;
        download_active_in <= r.dl;
        fault_in           <= fault_type'(r.flt);
        link_in            <= link_type'(r.lnk);
        repeat (110) @(posedge clock_in);
        @(negedge clock_in);
        check(32'(port_led[0]), 32'(r.p0));
        check_pat(0, r.bus);
        check_pat(1, r.err);
        check_pat(2, r.p1);
    endtask

    task automatic wait_bus(input logic lvl);
        int n;
        for (n = 0; n < 50 && bus_led !== lvl; n++) begin
            @(negedge clock_in);
        end
        if (n == 50) begin
            mismatches++;
            finish_test();
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rows[0] = '{full_exchange_state, 1'h0, 12'h000, 4'hC, 1'h1,
                    '{0, 1}, '{0, 0}, '{0, 1}};
        rows[1] = '{mailbox_only_state, 1'h0, 12'h200, 4'hE, 1'h1,
                    '{SLOW, 2*SLOW}, '{SLOW, 2*SLOW}, '{FAST, 2*FAST}};
        rows[2] = '{inputs_only_state, 1'h0, 12'h101, 4'h8, 1'h0,
                    '{SLOW, 2*PAUSE}, '{SLOW, 2*PAUSE}, '{0, 1}};
        rows[3] = '{st_booting, 1'h0, 12'h400, 4'h0, 1'h0,
                    '{FAST, 2*FAST}, '{SLOW, SLOW+PAUSE}, '{0, 0}};
        rows[4] = '{firmware_update_state, 1'h0, 12'hE00, 4'h4, 1'h1,
                    '{FAST, 2*FAST}, '{0, 1}, '{0, 0}};
        rows[5] = '{full_exchange_state, 1'h1, 12'h102, 4'hC, 1'h1,
                    '{FAST, 2*FAST}, '{0, 0}, '{0, 1}};
        rows[6] = '{st_init, 1'h0, 12'h001, 4'hC, 1'h1,
                    '{0, 0}, '{FAST, 2*FAST}, '{0, 1}};
        rows[7] = '{st_init, 1'h0, 12'h401, 4'hC, 1'h1,
                    '{0, 0}, '{SLOW, SLOW+PAUSE}, '{0, 1}};
        rows[8] = '{st_init, 1'h0, 12'h101, 4'hC, 1'h1,
                    '{0, 0}, '{FAST, 2*FAST}, '{0, 1}};
        repeat (10) @(posedge clock_in);
        @(negedge clock_in);
        check(32'({port_led, bus_led, err_led, hif_wd, app_wd, alias_out}),
              32'h0);
        @(posedge clock_in);
        rst_in <= 1'h0;
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // latched watchdogs, set against acknowledge, then acknowledge
        @(posedge clock_in);
        fault_in     <= fault_type'(12'hC00);
        error_ack_in <= 1'h1;
        @(posedge clock_in);
        fault_in     <= '0;
        error_ack_in <= 1'h0;
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        check(32'({hif_wd, app_wd, err_led}), 32'h7);
        repeat (30) @(posedge clock_in);
        @(negedge clock_in);
        check(32'(err_led), 32'h1);
        @(posedge clock_in);
        error_ack_in <= 1'h1;
        @(posedge clock_in);
        error_ack_in <= 1'h0;
        repeat (4) @(posedge clock_in);
        @(negedge clock_in);
        check(32'({hif_wd, app_wd, err_led}), 32'h0);
        // pattern change restarts lit
        @(posedge clock_in);
        bus_state_in <= mailbox_only_state;
        @(negedge clock_in);
        wait_bus(1'h1);
        wait_bus(1'h0);
        @(posedge clock_in);
        bus_state_in <= inputs_only_state;
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        check(32'(bus_led), 32'h1);
        // station alias sources, network side taking precedence over tool
        @(posedge clock_in);
        alias_net_in <= '{1'h1, 16'h1234};
        @(posedge clock_in);
        alias_net_in  <= '{1'h1, 16'hABCD};
        alias_tool_in <= '{1'h1, 16'h5555};
        @(negedge clock_in);
        check(32'(alias_out), 32'h1234);
        @(posedge clock_in);
        alias_net_in  <= '0;
        alias_tool_in <= '{1'h1, 16'h0F0F};
        @(negedge clock_in);
        check(32'(alias_out), 32'hABCD);
        @(posedge clock_in);
        alias_tool_in <= '0;
        @(negedge clock_in);
        check(32'(alias_out), 32'h0F0F);
        // reset in mid-run, then recovery
        @(posedge clock_in);
        rst_in <= 1'h1;
        @(negedge clock_in);
        check(32'({port_led, bus_led, err_led, hif_wd, app_wd, alias_out}),
              32'h0);
        @(posedge clock_in);
        rst_in <= 1'h0;
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        check(32'({port_led, bus_led, err_led, alias_out}),
              32'h000E0000);
        finish_test();
    end

endmodule

// [tb/led_viewer.sv]
`timescale 1ns/1ns
module led_viewer (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // lamp seen by the operator
    input  wire logic        led_in,
    // measured run lengths in clocks
    output logic [31:0]      on_len_out,
    output logic [31:0]      off_sum_out,
    output logic [31:0]      cur_len_out
);

    // ****************************************
    // run length capture
    // ****************************************
    logic        prev_q;
    logic [31:0] off_last_q;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prev_q      <= 1'h0;
            off_last_q  <= 32'h0;
            on_len_out  <= 32'h0;
            off_sum_out <= 32'h0;
            cur_len_out <= 32'h1;
        end else if (led_in != prev_q) begin
            if (prev_q) begin
                on_len_out <= cur_len_out;
            end else begin
                off_sum_out <= off_last_q + cur_len_out;
                off_last_q  <= cur_len_out;
            end
            cur_len_out <= 32'h1;
            prev_q      <= led_in;
        end else begin
            cur_len_out <= cur_len_out + 32'h1;
        end
    end

endmodule
